// >>> common/pfd_pkg.sv
// Package: register map, field layout, reset values and limits of the second PLL configuration
package pfd_pkg;
   // ==========================================================================
   // Register offsets (byte addresses on the serial register port)
   // ==========================================================================
   localparam logic [7:0] PFD_SET0_BASE = 8'h28;
   localparam logic [7:0] PFD_SET1_BASE = 8'h2c;
   localparam logic [7:0] PFD_SET1_FB_HIGH = 8'h2c;
   localparam logic [7:0] PFD_SET1_FB_LOW_REM_HIGH = 8'h2d;
   localparam logic [7:0] PFD_SET1_REM_LOW_QUOT_HIGH = 8'h2e;
   localparam logic [7:0] PFD_SET1_QUOT_LOW_SHIFT_RANGE = 8'h2f;
   localparam int PFD_NUM_BYTES = 8;
   // ==========================================================================
   // Field widths and positions inside the 32-bit concatenation of one set
   // ==========================================================================
   localparam int PFD_N_W = 12;
   localparam int PFD_R_W = 9;
   localparam int PFD_Q_W = 6;
   localparam int PFD_P_W = 3;
   localparam int PFD_B_W = 2;
   localparam int PFD_N_LSB = 20;
   localparam int PFD_R_LSB = 11;
   localparam int PFD_Q_LSB = 5;
   localparam int PFD_P_LSB = 2;
   localparam int PFD_B_LSB = 0;
   // ==========================================================================
   // Reset values
   // ==========================================================================
   localparam logic [11:0] PFD_N_RST = 12'h004;
   localparam logic [8:0]  PFD_R_RST = 9'h000;
   localparam logic [5:0]  PFD_Q_RST = 6'h10;
   localparam logic [2:0]  PFD_P_RST = 3'h2;
   localparam logic [1:0]  PFD_B_RST = 2'h0;
   localparam logic [31:0] PFD_SET_RST = {PFD_N_RST, PFD_R_RST, PFD_Q_RST, PFD_P_RST, PFD_B_RST};
   // ==========================================================================
   // Limits and thresholds
   // ==========================================================================
   localparam logic [11:0] PFD_M_MAX = 12'h1ff;
   localparam logic [11:0] PFD_N_MAX = 12'hfff;
   localparam logic [5:0]  PFD_Q_MIN = 6'h10;
   localparam logic [5:0]  PFD_Q_MAX = 6'h3f;
   localparam logic [2:0]  PFD_P_BASE = 3'h4;
   localparam int PFD_LOG_STEPS = 12;
   localparam logic [31:0] PFD_VCO_T1_KHZ = 32'd125000;
   localparam logic [31:0] PFD_VCO_T2_KHZ = 32'd150000;
   localparam logic [31:0] PFD_VCO_T3_KHZ = 32'd175000;
   localparam int PFD_DIV_W = 32;
   localparam int PFD_DVS_W = 12;
   localparam logic [5:0] PFD_DIV_STEPS = 6'd32;
   localparam int PFD_PDIV_W = 7;
   localparam int PFD_FIN_W = 18;
endpackage : pfd_pkg

// >>> common/pfd_div_if.sv
// Interface: request and answer of the shared sequential divider
`timescale 1ns/10ps
`default_nettype none
interface pfd_div_if;
   import pfd_pkg::*;
   logic                 start;
   logic [PFD_DIV_W-1:0] dividend;
   logic [PFD_DVS_W-1:0] divisor;
   logic                 busy;
   logic                 done;
   logic [PFD_DIV_W-1:0] quot;
   logic [PFD_DVS_W-1:0] rem;
   modport master (output start, output dividend, output divisor,
                   input busy, input done, input quot, input rem);
   modport slave  (input start, input dividend, input divisor,
                   output busy, output done, output quot, output rem);
endinterface : pfd_div_if
`default_nettype wire

// >>> design/pfd_divider.sv
// Restoring divider, one quotient bit per clock
`timescale 1ns/10ps
`default_nettype none
module pfd_divider
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Divider port
   pfd_div_if.slave dv
);
   logic [PFD_DIV_W-1:0] q;
   logic [PFD_DVS_W:0]   r;
   logic [PFD_DVS_W-1:0] dvs;
   logic [PFD_DIV_W-1:0] dvd_hold;
   logic [5:0]           cnt;
   logic                 done;
   // ==========================================================================
   // Shift and subtract datapath
   // ==========================================================================
   wire logic [PFD_DVS_W:0] r_sh  = {r[PFD_DVS_W-1:0], q[PFD_DIV_W-1]};
   wire logic               fits  = r_sh >= {1'b0, dvs};
   wire logic [PFD_DVS_W:0] r_sub = r_sh - {1'b0, dvs};

   // A new request is ignored while busy; the caller waits for done
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
         r <= '0;
         dvs <= '0;
         dvd_hold <= '0;
         cnt <= '0;
         done <= 1'b0;
      end else if (dv.start && cnt == 6'd0) begin
         q <= dv.dividend;
         r <= '0;
         dvs <= dv.divisor;
         dvd_hold <= dv.dividend;
         cnt <= PFD_DIV_STEPS;
         done <= 1'b0;
      end else if (cnt != 6'd0) begin
         r <= fits ? r_sub : r_sh;
         q <= {q[PFD_DIV_W-2:0], fits};
         cnt <= cnt - 6'd1;
         done <= cnt == 6'd1;
      end else begin
         done <= 1'b0;
      end
   end

   assign dv.busy = cnt != 6'd0;
   assign dv.done = done;
   assign dv.quot = q;
   assign dv.rem  = r[PFD_DVS_W-1:0];

   // ==========================================================================
   // Checks
   // ==========================================================================
   AST_DIV_EXACT: assert property (@(posedge clk) disable iff (rst)
      done && dvs != '0 |-> 44'(q) * 44'(dvs) + 44'(r) == 44'(dvd_hold))
      else $error("quotient times divisor plus remainder differs from dividend");
   AST_REM_BELOW: assert property (@(posedge clk) disable iff (rst)
      done && dvs != '0 |-> r < {1'b0, dvs})
      else $error("remainder not below divisor");
endmodule : pfd_divider
`default_nettype wire

// >>> design/pfd_outdiv.sv
// Output divider: divides the synthesized tick stream by 1 to 127
`timescale 1ns/10ps
`default_nettype none
module pfd_outdiv
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // Control
   input wire logic                  enable,
   input wire logic [PFD_PDIV_W-1:0] pdiv,
   // Output
   output logic                      out_tick
);
   logic [PFD_PDIV_W-1:0] cnt;
   // Zero divider means standby: counter cleared, no ticks
   wire logic run  = enable && pdiv != '0;
   wire logic wrap = cnt >= pdiv - 7'd1;

   // One tick every pdiv clocks
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt <= '0;
         out_tick <= 1'b0;
      end else begin
         cnt <= wrap ? '0 : cnt + 7'd1;
         out_tick <= wrap;
      end
   end

   AST_TICK_SPACING: assert property (@(posedge clk) disable iff (rst)
      run && wrap && pdiv > 7'd1 ##1 run && $stable(pdiv) |-> out_tick && cnt == 7'd0 ##1 !out_tick)
      else $error("output divider tick spacing wrong");
endmodule : pfd_outdiv
`default_nettype wire

// >>> design/pfd_config.sv
// Second PLL configuration: two parameter sets, P/Q/R calculator, state select, power-up gating
// How it works
// - Band code 00 below 125, 01 to 150, 10 to 175, 11 above MHz.
// - M must be 1..511 and N 1..4095; other requests are flagged invalid.
// - Output divider 1..127; output frequency is input times N/M over divider.
// - VCO frequency equals input frequency times N over M, undivided.
// - P is 4 minus floor log2 of N/M, clamped at zero.
// - Q is N' divided by M; R is the remainder.
// - N' is N shifted left by P; N must not be below M.
// - Set 1 N sits at 2Ch and 2Dh upper nibble, reset 004h; R follows.
// - R low bits, Q, P and band sit in 2Eh and 2Fh with resets.
// - Active-set outputs and the output divider stay disabled until the core supply is reported good.
// - State select bit picks set 0 or set 1 as the active set.
`timescale 1ns/10ps
`default_nettype none
module pfd_config
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic                   clk,
   input wire logic                   rst,
   // Register port from the serial interface
   input wire logic                   reg_wr,
   input wire logic [7:0]             reg_addr,
   input wire logic [7:0]             reg_wdata,
   output logic     [7:0]             reg_rdata,
   // Calculator request
   input wire logic                   calc_start,
   input wire logic                   calc_set,
   input wire logic [PFD_N_W-1:0]     calc_n,
   input wire logic [PFD_N_W-1:0]     calc_m,
   input wire logic [PFD_FIN_W-1:0]   fin_khz,
   output logic                       calc_busy,
   output logic                       calc_done,
   output logic                       cfg_invalid,
   output logic     [31:0]            vco_khz,
   output logic     [31:0]            fout_khz,
   // Pins
   input wire logic                   state_sel_pin,
   input wire logic                   core_supply_ok_pin,
   input wire logic [PFD_PDIV_W-1:0]  pdiv,
   // Active set and outputs
   output logic     [PFD_N_W-1:0]     act_feedback,
   output logic     [PFD_R_W-1:0]     act_remainder,
   output logic     [PFD_Q_W-1:0]     act_quotient,
   output logic     [PFD_P_W-1:0]     act_shift,
   output logic     [PFD_B_W-1:0]     act_vco_band,
   output logic                       out_enable,
   output logic                       out_tick
);
   typedef enum logic [2:0] {ST_IDLE, ST_QUOT, ST_VCO, ST_OUT} pfd_state_e;

   pfd_state_e           state;
   logic [7:0]           regs [PFD_NUM_BYTES];
   logic                 sel_s1, sel_s2, pg_s1, pg_s2;
   logic                 set_lat, div_start;
   logic [PFD_N_W-1:0]   n_lat, m_lat;
   logic [PFD_P_W-1:0]   p_lat;
   logic [15:0]          nprime_lat;
   logic [PFD_Q_W-1:0]   q_lat;
   logic [PFD_R_W-1:0]   r_lat;
   logic                 q_bad;
   pfd_div_if            dv ();

   // ==========================================================================
   // Pin synchronisers: select and supply-good come from off-chip
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_s1 <= 1'b0;
         sel_s2 <= 1'b0;
         pg_s1 <= 1'b0;
         pg_s2 <= 1'b0;
      end else begin
         sel_s1 <= state_sel_pin;
         sel_s2 <= sel_s1;
         pg_s1 <= core_supply_ok_pin;
         pg_s2 <= pg_s1;
      end
   end

   // ==========================================================================
   // Field views of both sets
   // ==========================================================================
   wire logic [31:0] set0_word = {regs[0], regs[1], regs[2], regs[3]};
   wire logic [31:0] set1_word = {regs[4], regs[5], regs[6], regs[7]};
   wire logic [31:0] act_word  = sel_s2 ? set1_word : set0_word;
   wire logic [PFD_N_W-1:0] second_pll_set1_feedback = set1_word[PFD_N_LSB +: PFD_N_W];
   wire logic [PFD_R_W-1:0] second_pll_set1_remainder = set1_word[PFD_R_LSB +: PFD_R_W];
   wire logic [PFD_Q_W-1:0] second_pll_set1_quotient = set1_word[PFD_Q_LSB +: PFD_Q_W];
   wire logic [PFD_P_W-1:0] second_pll_set1_shift = set1_word[PFD_P_LSB +: PFD_P_W];
   wire logic [PFD_B_W-1:0] second_pll_set1_vco_band = set1_word[PFD_B_LSB +: PFD_B_W];
   wire logic [PFD_B_W-1:0] second_pll_set0_vco_band = set0_word[PFD_B_LSB +: PFD_B_W];

   // ==========================================================================
   // Request check and shift computation
   // ==========================================================================
   wire logic range_ok = calc_m != '0 && calc_m <= PFD_M_MAX && calc_n != '0 && calc_n <= PFD_N_MAX;
   wire logic order_ok = calc_n >= calc_m;
   wire logic req_ok   = range_ok && order_ok;
   logic [PFD_LOG_STEPS-1:0] m_fits;
   // One compare per power of two: M shifted by k still not above N
   generate
      for (genvar k = 0; k < PFD_LOG_STEPS; k++) begin : g_log
         assign m_fits[k] = (24'(calc_m) << k) <= 24'(calc_n);
      end
   endgenerate
   wire logic [3:0] log_int = 4'($countones(m_fits)) - 4'd1;
   wire logic [PFD_P_W-1:0] p_calc = (log_int >= 4'(PFD_P_BASE)) ? 3'd0 : PFD_P_BASE - log_int[2:0];
   wire logic [15:0] nprime = 16'(calc_n) << p_calc;

   // ==========================================================================
   // Divider operands per step and result decoding
   // ==========================================================================
   assign dv.start    = div_start;
   assign dv.dividend = state == ST_QUOT ? 32'(nprime_lat)
                      : state == ST_VCO  ? 32'(fin_khz) * 32'(n_lat)
                      : dv.quot;
   assign dv.divisor  = state == ST_OUT ? 12'(pdiv) : m_lat;
   wire logic [PFD_B_W-1:0] band_calc = vco_khz < PFD_VCO_T1_KHZ ? 2'b00
                                      : vco_khz < PFD_VCO_T2_KHZ ? 2'b01
                                      : vco_khz < PFD_VCO_T3_KHZ ? 2'b10 : 2'b11;
   wire logic q_in_range = dv.quot >= 32'(PFD_Q_MIN) && dv.quot <= 32'(PFD_Q_MAX);
   wire logic [31:0] new_word = {n_lat, r_lat, q_lat, p_lat, band_calc};
   // A set is rewritten only when Q landed in range; a bad Q leaves the old
   // set in force so the loop never runs on a ratio it cannot hold, at the
   // cost of the host having to read cfg_invalid to learn the result was dropped
   wire logic commit = state == ST_OUT && (dv.done || pdiv == '0) && !q_bad;
   wire logic [7:0] rd_idx = reg_addr - PFD_SET0_BASE;
   wire logic addr_hit = reg_addr >= PFD_SET0_BASE && reg_addr <= PFD_SET1_QUOT_LOW_SHIFT_RANGE;

   pfd_divider u_div (
      .clk (clk),
      .rst (rst),
      .dv  (dv)
   );

   // ==========================================================================
   // Calculator sequence: Q and R, then VCO, then output frequency
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= ST_IDLE;
         div_start <= 1'b0;
         set_lat <= 1'b0;
         n_lat <= '0;
         m_lat <= '0;
         p_lat <= '0;
         nprime_lat <= '0;
         q_lat <= '0;
         r_lat <= '0;
         q_bad <= 1'b0;
         cfg_invalid <= 1'b0;
         calc_done <= 1'b0;
         vco_khz <= '0;
         fout_khz <= '0;
      end else begin
         div_start <= 1'b0;
         calc_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (calc_start) begin
                  cfg_invalid <= !req_ok;
                  q_bad <= 1'b0;
                  if (req_ok) begin
                     set_lat <= calc_set;
                     n_lat <= calc_n;
                     m_lat <= calc_m;
                     p_lat <= p_calc;
                     nprime_lat <= nprime;
                     div_start <= 1'b1;
                     state <= ST_QUOT;
                  end
               end
            end
            ST_QUOT: begin
               if (dv.done) begin
                  q_lat <= dv.quot[PFD_Q_W-1:0];
                  r_lat <= dv.rem[PFD_R_W-1:0];
                  q_bad <= !q_in_range;
                  div_start <= 1'b1;
                  state <= ST_VCO;
               end
            end
            ST_VCO: begin
               if (dv.done) begin
                  vco_khz <= dv.quot;
                  div_start <= pdiv != '0;
                  state <= ST_OUT;
               end
            end
            ST_OUT: begin
               if (dv.done || pdiv == '0) begin
                  fout_khz <= pdiv == '0 ? 32'd0 : dv.quot;
                  cfg_invalid <= q_bad;
                  calc_done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ==========================================================================
   // Register bytes: calculator result wins over a host write in the same cycle
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < PFD_NUM_BYTES; i++) begin
            regs[i] <= PFD_SET_RST[31 - 8 * (i % 4) -: 8];
         end
      end else if (commit) begin
         for (int i = 0; i < 4; i++) begin
            regs[set_lat ? i + 4 : i] <= new_word[31 - 8 * i -: 8];
         end
      end else if (reg_wr && addr_hit) begin
         regs[rd_idx[2:0]] <= reg_wdata;
      end
   end

   // ==========================================================================
   // Outputs: all registered, forced quiet until the supply is good
   // ==========================================================================
   always_ff @(posedge clk) begin
      if (rst || !pg_s2) begin
         act_feedback <= '0;
         act_remainder <= '0;
         act_quotient <= '0;
         act_shift <= '0;
         act_vco_band <= '0;
         out_enable <= 1'b0;
      end else begin
         act_feedback <= act_word[PFD_N_LSB +: PFD_N_W];
         act_remainder <= act_word[PFD_R_LSB +: PFD_R_W];
         act_quotient <= act_word[PFD_Q_LSB +: PFD_Q_W];
         act_shift <= act_word[PFD_P_LSB +: PFD_P_W];
         act_vco_band <= act_word[PFD_B_LSB +: PFD_B_W];
         out_enable <= 1'b1;
      end
   end

   // Read data and busy; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
         calc_busy <= 1'b0;
      end else begin
         reg_rdata <= addr_hit ? regs[rd_idx[2:0]] : 8'h00;
         calc_busy <= (state != ST_IDLE) || (calc_start && req_ok);
      end
   end

   pfd_outdiv u_outdiv (
      .clk      (clk),
      .rst      (rst),
      .enable   (out_enable),
      .pdiv     (pdiv),
      .out_tick (out_tick)
   );

   // ==========================================================================
   // Checks
   // ==========================================================================
   sequence s_go;
      state == ST_IDLE && calc_start && req_ok;
   endsequence
   sequence s_reject;
      state == ST_IDLE && calc_start && !req_ok;
   endsequence
   AST_BAND_CODE: assert property (@(posedge clk) disable iff (rst)
      commit |-> (band_calc == 2'b00) == (vco_khz < 32'd125000) && (band_calc == 2'b11) == (vco_khz >= 32'd175000))
      else $error("VCO band code does not match computed VCO frequency");
   AST_REJECT: assert property (@(posedge clk) disable iff (rst)
      s_reject |=> cfg_invalid && state == ST_IDLE && !calc_busy)
      else $error("out of range request not rejected");
   AST_VCO_VALUE: assert property (@(posedge clk) disable iff (rst)
      state == ST_VCO && dv.done |=> 44'(vco_khz) * 44'(m_lat) <= 44'(fin_khz) * 44'(n_lat))
      else $error("VCO frequency above input times N over M");
   AST_SHIFT: assert property (@(posedge clk) disable iff (rst)
      s_go |=> (32'(n_lat) >= 32'(m_lat) * 32'd16) == (p_lat == 3'd0) && p_lat <= 3'd4)
      else $error("shift setting wrong");
   AST_NPRIME: assert property (@(posedge clk) disable iff (rst)
      s_go |=> nprime_lat == 16'(n_lat) << p_lat)
      else $error("N prime is not N shifted by P");
   AST_RESET_FIELDS: assert property (@(posedge clk)
      $fell(rst) |-> second_pll_set1_feedback == 12'h004 && second_pll_set1_remainder == 9'h000
         && second_pll_set1_quotient == 6'h10 && second_pll_set1_shift == 3'h2 && second_pll_set1_vco_band == 2'h0)
      else $error("set 1 fields not at reset values");
   AST_SUPPLY_GATE: assert property (@(posedge clk) disable iff (rst)
      !core_supply_ok_pin [*4] |=> !out_enable && !out_tick)
      else $error("outputs enabled without core supply");
   AST_SELECT: assert property (@(posedge clk) disable iff (rst)
      pg_s2 && sel_s2 |=> act_feedback == $past(second_pll_set1_feedback) || !pg_s2)
      else $error("state 1 not selected");
   AST_Q_FLAG: assert property (@(posedge clk) disable iff (rst)
      calc_done |-> cfg_invalid || (q_lat >= PFD_Q_MIN && q_lat <= PFD_Q_MAX))
      else $error("quotient range flag wrong");
endmodule : pfd_config
`default_nettype wire

// >>> verif/pfd_host_model.sv
// Host model: drives the byte-wide register port of the configuration block
`timescale 1ns/10ps
`default_nettype none
module pfd_host_model (
   // Clock
   input wire logic       clk,
   // Register port
   output logic           reg_wr,
   output logic     [7:0] reg_addr,
   output logic     [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle port; data line starts as a pattern, not a real value
   initial begin
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h5a;
   end
   // ==========================================================================
   // Access tasks
   // ==========================================================================
   // One strobe per byte; raw bytes only, range limits are the caller's duty
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d; // Released line must not keep the old value
   endtask : wr
   // Read data lands one edge after the address is driven
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : pfd_host_model
`default_nettype wire

// >>> verif/pll_fraction_divider_config_test.sv
// Testbench: register map, calculator, state select and supply gating
`timescale 1ns/10ps
`default_nettype none
module pll_fraction_divider_config_test;
   import pfd_pkg::*;
   logic        clk, rst, reg_wr, cs, cset, ssel, sup, busy, done, inv, oen, tick;
   logic [7:0]  ra, wd, rd, v;
   logic [11:0] cn, cm, afb;
   logic [17:0] fin;
   logic [6:0]  pdiv;
   logic [31:0] vco, fout;
   logic [8:0]  arem;
   logic [5:0]  aq;
   logic [2:0]  ap;
   logic [1:0]  ab;
   int          err_count, checked, cnt;
   // Calculator cases: N, M, expected VCO kHz, band, Q, R (all give P = 2)
   int tn[4] = '{11, 4, 6, 40};
   int tm[4] = '{2, 1, 1, 6};
   int tv[4] = '{148500, 108000, 162000, 180000};
   int tb[4] = '{1, 0, 2, 3};
   int tq[4] = '{22, 16, 24, 26};
   int tr[4] = '{0, 0, 0, 4};
   logic [7:0] rv[4] = '{8'h00, 8'h40, 8'h02, 8'h08};
   pfd_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rd));
   pfd_config DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rd),
      .calc_start(cs), .calc_set(cset), .calc_n(cn), .calc_m(cm), .fin_khz(fin), .calc_busy(busy),
      .calc_done(done), .cfg_invalid(inv), .vco_khz(vco), .fout_khz(fout), .state_sel_pin(ssel),
      .core_supply_ok_pin(sup), .pdiv(pdiv), .act_feedback(afb), .act_remainder(arem),
      .act_quotient(aq), .act_shift(ap), .act_vco_band(ab), .out_enable(oen), .out_tick(tick));
   // ==========================================================================
   // Helpers
   // ==========================================================================
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Start pulse, then a bounded wait for the done pulse
   task automatic calc(input int n, input int m, input int lim, input logic want);
      int k;
      k = 0;
      @(posedge clk);
      cs <= 1'b1;
      cn <= 12'(n);
      cm <= 12'(m);
      @(posedge clk);
      cs <= 1'b0;
      @(negedge clk);
      chk("calc busy", busy, want);
      while (k < lim && done !== 1'b1) begin
         @(negedge clk);
         k++;
      end
      chk("calc done", done, want);
      repeat (4) @(negedge clk);
   endtask : calc
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // ==========================================================================
   // Clock and watchdog
   // ==========================================================================
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is well under a few thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      stop_test();
   end
   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      err_count = 0;
      checked = 0;
      rst = 1'b1;
      {cs, cset, ssel, sup} = 4'h2;
      cn = 12'h000;
      cm = 12'h000;
      fin = 18'd27000;
      pdiv = 7'h02;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         host.rd(8'h28 + 8'(i), v);
         chk("reset byte", v, rv[i % 4]);
      end
      host.rd(8'h30, v);
      chk("unmapped", v, 8'h00);
      chk("enable off", oen, 1'b0);
      chk("gated q", aq, 6'h00);
      host.wr(8'h2c, 8'haa);
      host.rd(8'h2c, v);
      chk("n high", v, 8'haa);
      @(posedge clk);
      sup <= 1'b1;
      repeat (5) @(negedge clk);
      chk("enable on", oen, 1'b1);
      chk("set1 n", afb, 12'haa4);
      chk("set1 q", aq, 6'h10);
      chk("set1 p", ap, 3'h2);
      @(posedge clk);
      ssel <= 1'b0;
      repeat (5) @(negedge clk);
      chk("set0 n", afb, 12'h004);
      @(posedge clk);
      ssel <= 1'b1;
      cnt = 0;
      repeat (20) begin
         @(negedge clk);
         cnt += int'(tick);
      end
      chk("ticks", cnt, 10);
      @(posedge clk);
      cset <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         calc(tn[i], tm[i], 400, 1'b1);
         chk("vco", vco, tv[i]);
         chk("fout", fout, tv[i] / 2);
         chk("band", ab, tb[i]);
         chk("q", aq, tq[i]);
         chk("r", arem, tr[i]);
         chk("p", ap, 3'h2);
         chk("valid", inv, 1'b0);
      end
      // Last case is N = 40: bytes 02 80 23 4b
      rv = '{8'h02, 8'h80, 8'h23, 8'h4b};
      for (int i = 0; i < 4; i++) begin
         host.rd(8'h2c + 8'(i), v);
         chk("packed byte", v, rv[i]);
      end
      // N = 11, M = 2 into set 0: byte 29 is b0, set 1 keeps its last word
      @(posedge clk);
      cset <= 1'b0;
      calc(11, 2, 400, 1'b1);
      host.rd(8'h29, v);
      chk("set0 byte", v, 8'hb0);
      host.rd(8'h2f, v);
      chk("set1 kept", v, 8'h4b);
      // Zero M, N below M, M past its limit
      tn = '{5, 3, 600, 0};
      tm = '{0, 5, 512, 0};
      for (int i = 0; i < 3; i++) begin
         calc(tn[i], tm[i], 10, 1'b0);
         chk("invalid", inv, 1'b1);
         chk("no busy", busy, 1'b0);
      end
      chk("kept q", aq, 6'd26);
      // N/M = 64 gives P = 0 and Q = 64: flagged, set untouched; divider in standby
      @(posedge clk);
      pdiv <= 7'h00;
      calc(64, 1, 400, 1'b1);
      chk("q range", inv, 1'b1);
      chk("vco 64", vco, 32'd1728000);
      chk("standby fout", fout, 32'd0);
      chk("q untouched", aq, 6'd26);
      cnt = 0;
      repeat (6) begin
         @(negedge clk);
         cnt += int'(tick);
      end
      chk("standby ticks", cnt, 0);
      stop_test();
   end
endmodule : pll_fraction_divider_config_test
`default_nettype wire
